// *** src/cbu_unit.sv ***
// How it works
// - E2: decrement count, branch if nonzero
// - count reaches zero: fall through
// - count is an unsigned loop count
// - displacement reach is -128 to +127
// - extend displacement by mask, add to pointer
// - E1: branch if count nonzero and zero flag
// - equal form falls through otherwise
// - branch executes in 16 or 6 clocks
// - string load always advances its index
`timescale 1ns/1ps
`include "cbu_map.svh"

module cbu_unit #(
    parameter int CLK_TAKEN  = `CBU_CLK_TAKEN,
    parameter int CLK_FALL   = `CBU_CLK_FALL,
    parameter int CLK_STRING = `CBU_CLK_STRING
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire cbu_pkg::cbu_req_s req,
    output logic                   rsp_valid,
    output cbu_pkg::cbu_rsp_s      rsp,
    output logic                   illegal
);

    // each clock count must fit the 5-bit field and be at least one
    if (CLK_TAKEN < 1 || CLK_TAKEN > 31) begin : g_bad_taken
        $error("cbu_unit: CLK_TAKEN out of range 1..31");
    end
    if (CLK_FALL < 1 || CLK_FALL > 31) begin : g_bad_fall
        $error("cbu_unit: CLK_FALL out of range 1..31");
    end
    if (CLK_STRING < 1 || CLK_STRING > 31) begin : g_bad_string
        $error("cbu_unit: CLK_STRING out of range 1..31");
    end

    typedef enum logic [0:0] {
        CBU_IDLE = 1'b0,
        CBU_BUSY = 1'b1
    } cbu_state_e;

    // sign extension by mask, so no arithmetic shift is needed
    function automatic logic [15:0] extend_disp(input logic [7:0] d);
        logic [15:0] w;
        w = {8'h00, d};
        if (d[`CBU_SIGN_BIT])
            extend_disp = `CBU_EXT_NEG | w;
        else
            extend_disp = `CBU_EXT_POS & w;
    endfunction : extend_disp

    // index steps by element size, downwards when the flag is set
    function automatic logic [15:0] advance_index(
        input logic [15:0] idx,
        input logic        down,
        input logic        word
    );
        logic [15:0] step;
        step = word ? 16'h0002 : 16'h0001;
        if (down)
            advance_index = idx - step;
        else
            advance_index = idx + step;
    endfunction : advance_index

    cbu_pkg::cbu_kind_e kind;
    logic               is_word;

    // opcode classification lives in its own leaf
    cbu_decode u_decode (
        .opcode  (req.opcode),
        .kind    (kind),
        .is_word (is_word)
    );

    // control group: sequencing of the execution clocks
    cbu_state_e        state;
    cbu_state_e        next_state;
    logic [4:0]        wait_cnt;
    logic [4:0]        next_wait_cnt;
    logic              next_rsp_valid;
    logic              next_illegal;

    // result group: architectural values handed back
    cbu_pkg::cbu_rsp_s next_rsp;

    // decision on the instruction offered this cycle
    logic              accept;
    logic              is_branch;
    logic              take;
    logic [15:0]       dec_count;
    logic [15:0]       seq_ip;
    logic [15:0]       target_ip;
    logic [4:0]        exec_clocks;

    // decrement first, then test the new count
    always_comb begin
        // unsigned wrap: zero on entry becomes all ones
        dec_count = req.count - 16'h0001;
        // ip is taken as the address of the instruction itself
        if (kind == cbu_pkg::CBU_KIND_STRING)
            seq_ip = req.ip + `CBU_STRING_LEN;
        else
            seq_ip = req.ip + `CBU_BRANCH_LEN;
        // offset reaches -128..+127 from the branch itself
        target_ip = req.ip + extend_disp(req.disp);
        is_branch = (kind == cbu_pkg::CBU_KIND_LOOP) ||
                    (kind == cbu_pkg::CBU_KIND_LOOPEQ);
        case (kind)
            cbu_pkg::CBU_KIND_LOOP: begin
                take = (dec_count != 16'h0000);
            end
            cbu_pkg::CBU_KIND_LOOPEQ: begin
                // a clear zero flag ends the loop early
                take = (dec_count != 16'h0000) &&
                       req.zero_flag;
            end
            default: begin
                take = 1'b0;
            end
        endcase
        // a taken branch costs the longer count
        case (kind)
            cbu_pkg::CBU_KIND_LOOP,
            cbu_pkg::CBU_KIND_LOOPEQ: begin
                exec_clocks = take ? 5'(CLK_TAKEN)
                                   : 5'(CLK_FALL);
            end
            cbu_pkg::CBU_KIND_STRING: begin
                exec_clocks = 5'(CLK_STRING);
            end
            default: begin
                // unknown opcodes answer at once and are flagged
                exec_clocks = 5'h01;
            end
        endcase
    end

    // single instruction in flight; ready only when idle
    assign req_ready = (state == CBU_IDLE);
    assign accept    = req_valid && req_ready;

    // counts run down so the answer lands on the last clock
    always_comb begin
        next_state     = state;
        next_wait_cnt  = wait_cnt;
        next_rsp_valid = 1'b0;
        next_illegal   = 1'b0;
        case (state)
            CBU_IDLE: begin
                if (accept) begin
                    next_wait_cnt = exec_clocks - 5'h01;
                    if (exec_clocks == 5'h01) begin
                        next_rsp_valid = 1'b1;
                        next_illegal   = (kind == cbu_pkg::CBU_KIND_NONE);
                    end else begin
                        next_state = CBU_BUSY;
                    end
                end
            end
            CBU_BUSY: begin
                next_wait_cnt = wait_cnt - 5'h01;
                if (wait_cnt == 5'h01) begin
                    next_rsp_valid = 1'b1;
                    next_state     = CBU_IDLE;
                end
            end
            default: begin
                next_state    = CBU_IDLE;
                next_wait_cnt = 5'h00;
            end
        endcase
    end

    // control registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state     <= CBU_IDLE;
            wait_cnt  <= 5'h00;
            rsp_valid <= 1'b0;
            illegal   <= 1'b0;
        end else begin
            state     <= next_state;
            wait_cnt  <= next_wait_cnt;
            rsp_valid <= next_rsp_valid;
            illegal   <= next_illegal;
        end
    end

    // results change at the taking edge; read them with rsp_valid
    always_comb begin
        next_rsp = rsp;
        if (accept) begin
            next_rsp.count             = req.count;
            next_rsp.src_index         = req.src_index;
            next_rsp.destination_index = req.destination_index;
            next_rsp.taken             = take;
            next_rsp.clocks            = exec_clocks;
            if (take)
                next_rsp.next_ip = target_ip;
            else
                next_rsp.next_ip = seq_ip;
            if (is_branch)
                next_rsp.count = dec_count;
            // advance regardless of the iterate prefix
            if (kind == cbu_pkg::CBU_KIND_STRING)
                next_rsp.src_index = advance_index(req.src_index,
                    req.direction_flag, is_word);
        end
    end

    // flags never pass through this unit, so none can change
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            rsp <= '0;
        else
            rsp <= next_rsp;
    end

endmodule : cbu_unit

// *** common/cbu_map.svh ***
`ifndef CBU_MAP_SVH
`define CBU_MAP_SVH

// opcodes of the counted branches and the byte and word string loads
`define CBU_OP_LOOP        8'he2
`define CBU_OP_LOOP_EQ     8'he1
`define CBU_OP_LOAD_BYTE   8'hac
`define CBU_OP_LOAD_WORD   8'had

// sign extension masks for the short displacement
`define CBU_EXT_NEG        16'hff00
`define CBU_EXT_POS        16'h00ff
`define CBU_SIGN_BIT       7

// execution clock counts
`define CBU_CLK_TAKEN      16
`define CBU_CLK_FALL       6
`define CBU_CLK_STRING     12

// instruction lengths of a counted branch and a string load in bytes
`define CBU_BRANCH_LEN     16'h0002
`define CBU_STRING_LEN     16'h0001

`endif

// *** common/cbu_pkg.sv ***
package cbu_pkg;

    typedef enum logic [1:0] {
        CBU_KIND_NONE   = 2'b00,
        CBU_KIND_LOOP   = 2'b01,
        CBU_KIND_LOOPEQ = 2'b10,
        CBU_KIND_STRING = 2'b11
    } cbu_kind_e;

    // one instruction handed in by the execute stage
    typedef struct packed {
        logic [7:0]  opcode;
        logic [7:0]  disp;
        logic [15:0] ip;
        logic [15:0] count;
        logic [15:0] src_index;
        logic [15:0] destination_index;
        logic        zero_flag;
        logic        direction_flag;
        logic        iterate_prefix;
    } cbu_req_s;

    // architectural results handed back
    typedef struct packed {
        logic [15:0] next_ip;
        logic [15:0] count;
        logic [15:0] src_index;
        logic [15:0] destination_index;
        logic        taken;
        logic [4:0]  clocks;
    } cbu_rsp_s;

endpackage : cbu_pkg

// *** src/cbu_decode.sv ***
`timescale 1ns/1ps
`include "cbu_map.svh"

// classifies the opcode; pure combinational leaf
module cbu_decode (
    input  wire logic [7:0]         opcode,
    output cbu_pkg::cbu_kind_e      kind,
    output logic                    is_word
);

    // both assembler names of the equal form share one opcode
    always_comb begin
        is_word = 1'b0;
        case (opcode)
            `CBU_OP_LOOP:      kind = cbu_pkg::CBU_KIND_LOOP;
            `CBU_OP_LOOP_EQ:   kind = cbu_pkg::CBU_KIND_LOOPEQ;
            `CBU_OP_LOAD_BYTE: kind = cbu_pkg::CBU_KIND_STRING;
            `CBU_OP_LOAD_WORD: begin
                kind    = cbu_pkg::CBU_KIND_STRING;
                is_word = 1'b1;
            end
            default:           kind = cbu_pkg::CBU_KIND_NONE;
        endcase
    end

endmodule : cbu_decode

// *** tb/cbu_unit_chk.sv ***
`timescale 1ns/1ps

module cbu_unit_chk (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              req_valid,
    input wire logic              req_ready,
    input wire cbu_pkg::cbu_req_s req,
    input wire logic              rsp_valid,
    input wire cbu_pkg::cbu_rsp_s rsp,
    input wire logic              illegal
);
    cbu_pkg::cbu_req_s held;
    logic [15:0]       dec;
    logic [15:0]       ext;
    logic              br;
    logic              go;
    // request in flight, kept until its answer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) held <= '0;
        else if (req_valid && req_ready) held <= req;
    end
    // decrement first, then test the new count
    assign dec = held.count - 16'h0001;
    assign ext = {{8{held.disp[7]}}, held.disp};
    assign br = held.opcode == 8'he2 || held.opcode == 8'he1;
    assign go = dec != 16'h0000 && (held.opcode == 8'he2 || held.zero_flag);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_take(logic last);
        req_valid && req_ready && req.opcode == 8'he2
            && (req.count == 16'h0001) == last;
    endsequence
    sequence s_quiet15;
        !rsp_valid[*8] ##1 !rsp_valid[*7];
    endsequence
    a_count_dec: assert property (rsp_valid && br |-> rsp.count == dec)
        else $error("count not decremented");
    a_taken_cond: assert property (rsp_valid && br |-> rsp.taken == go)
        else $error("branch decision wrong");
    a_fall_ip: assert property (rsp_valid && br && !go
        |-> rsp.next_ip == held.ip + 16'h0002) else $error("bad fall ip");
    a_target_ip: assert property (rsp_valid && br && go
        |-> rsp.next_ip == held.ip + ext) else $error("bad target");
    a_clock_count: assert property (rsp_valid && br
        |-> rsp.clocks == (go ? 5'h10 : 5'h06)) else $error("bad clocks");
    a_taken_wait: assert property (s_take(1'b0)
        |=> s_quiet15 ##1 rsp_valid) else $error("taken latency wrong");
    a_fall_wait: assert property (s_take(1'b1)
        |=> !rsp_valid[*5] ##1 rsp_valid) else $error("fall latency wrong");
    a_string_step: assert property (rsp_valid && held.opcode == 8'hac
        |-> rsp.src_index == held.src_index
            + (held.direction_flag ? 16'hffff : 16'h0001))
        else $error("index not advanced");
    a_illegal_pulse: assert property (illegal |-> rsp_valid)
        else $error("illegal without answer");
endmodule : cbu_unit_chk

bind cbu_unit cbu_unit_chk u_chk (.clk(clk), .rst(rst),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp(rsp), .illegal(illegal));

// *** tb/counted_branch_unit_tb_top.sv ***
`timescale 1ns/1ps

module counted_branch_unit_tb_top;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              req_valid = 1'b0;
    logic              req_ready;
    logic              rsp_valid;
    logic              illegal;
    cbu_pkg::cbu_req_s req = '0;
    cbu_pkg::cbu_rsp_s rsp;
    int                n_errors = 0;
    int                n_compared = 0;
    int                cyc = 0;
    logic              pfx = 1'b0;

    always #5 clk = ~clk;

    cbu_unit DUT (.clk(clk), .rst(rst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
        .rsp(rsp), .illegal(illegal));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task give_verdict;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    // offers one instruction at a falling edge, checks its answer
    task run(input logic [7:0] op, dsp, input logic [15:0] ip, cnt, src,
             input logic zf, df, input logic [15:0] e_ip, e_cnt, e_src,
             input logic tk, input int clks);
        int n;
        req = '{op, dsp, ip, cnt, src, 16'h5a5a, zf, df, pfx};
        req_valid = 1'b1;
        while (req_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        // the taking edge counts as the first execution clock
        n = 1;
        while (rsp_valid !== 1'b1) begin
            @(negedge clk);
            n++;
        end
        chk(n, clks);
        chk(rsp.clocks, clks);
        chk(rsp.next_ip, e_ip);
        chk(rsp.count, e_cnt);
        chk(rsp.taken, tk);
        chk(rsp.src_index, e_src);
        chk(rsp.destination_index, 16'h5a5a);
        chk(illegal, 1'b0);
    endtask : run

    task t_loop_taken; // backward reach, unsigned count
        run(8'he2, 8'hfe, 16'h0100, 16'h0002, 16'h0040, 1'b0, 1'b0,
            16'h00fe, 16'h0001, 16'h0040, 1'b1, 16);
    endtask : t_loop_taken

    task t_loop_fall; // last pass leaves the loop
        run(8'he2, 8'hfe, 16'h0100, 16'h0001, 16'h0040, 1'b1, 1'b0,
            16'h0102, 16'h0000, 16'h0040, 1'b0, 6);
    endtask : t_loop_fall

    task t_loop_wrap; // zero count wraps, farthest forward reach
        run(8'he2, 8'h7f, 16'h1000, 16'h0000, 16'h0040, 1'b0, 1'b1,
            16'h107f, 16'hffff, 16'h0040, 1'b1, 16);
    endtask : t_loop_wrap

    task t_equal; // zero flag gates the equal form
        run(8'he1, 8'h80, 16'h2000, 16'h0003, 16'h0040, 1'b1, 1'b0,
            16'h1f80, 16'h0002, 16'h0040, 1'b1, 16);
        run(8'he1, 8'h80, 16'h2000, 16'h0003, 16'h0040, 1'b0, 1'b0,
            16'h2002, 16'h0002, 16'h0040, 1'b0, 6);
        run(8'he1, 8'h80, 16'h2000, 16'h0001, 16'h0040, 1'b1, 1'b0,
            16'h2002, 16'h0000, 16'h0040, 1'b0, 6);
    endtask : t_equal

    task t_string; // index moves with or without the prefix
        run(8'hac, 8'h00, 16'h3000, 16'h0007, 16'h0040, 1'b0, 1'b0,
            16'h3001, 16'h0007, 16'h0041, 1'b0, 12);
        pfx = 1'b1;
        run(8'had, 8'h00, 16'h3000, 16'h0007, 16'h0040, 1'b0, 1'b1,
            16'h3001, 16'h0007, 16'h003e, 1'b0, 12);
        pfx = 1'b0;
    endtask : t_string

    task t_illegal; // undecoded opcode answers at once, flagged
        req = '{8'h90, 8'h00, 16'h4000, 16'h0005, 16'h0040, 16'h5a5a,
                1'b0, 1'b0, 1'b0};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        chk(rsp_valid, 1'b1);
        chk(illegal, 1'b1);
        chk(rsp.taken, 1'b0);
        chk(rsp.count, 16'h0005);
    endtask : t_illegal

    task t_reset; // reset in mid-flight drops the answer
        req = '{8'he2, 8'h10, 16'h5000, 16'h0009, 16'h0040, 16'h5a5a,
                1'b0, 1'b0, 1'b0};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        chk(req_ready, 1'b0);
        repeat (3) @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        chk(req_ready, 1'b1);
        chk(rsp_valid, 1'b0);
        chk(rsp.next_ip, 16'h0000);
        chk(rsp.count, 16'h0000);
        rst = 1'b0;
    endtask : t_reset

    // hang guard, far above the roughly 120 cycles needed
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_loop_taken();
        t_loop_fall();
        t_loop_wrap();
        t_equal();
        t_illegal();
        t_reset();
        t_string();
        give_verdict();
    end
endmodule : counted_branch_unit_tb_top
